// >>> pkg/timer_oc_map.svh
// offsets, field positions and reset values of the output compare pair
// assumes: included by bare name from pkg/ on the include path
`ifndef TIMER_OC_MAP_SVH
`define TIMER_OC_MAP_SVH

// compare byte registers
`define COMPARE_ONE_HIGH 8'h22
`define COMPARE_ONE_LOW 8'h23
`define COMPARE_TWO_HIGH 8'h26
`define COMPARE_TWO_LOW 8'h27

// control, flag and counter registers
`define TIMER_CONTROL_REG 8'h2e
`define TIMER_FLAG_REGISTER 8'h2f
`define COUNT_HIGH_REG 8'h30
`define COUNT_LOW_REG 8'h31

// control field positions
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h00

// reset values
`define COUNT_RESET 16'hfffc
`define RDATA_RESET 8'h00
`define CAPTURE_CLEAR 16'h0000

`endif

// >>> pkg/timer_oc_pkg.sv
// types shared by the output compare pair and its channel module
// assumes: compiled before any file under hw/
package timer_oc_pkg;

  // one timer count spans four bus clocks, one phase each
  typedef enum logic [1:0] {
    timer_phase_idle = 2'b00,
    timer_phase_compare = 2'b01,
    timer_phase_sample = 2'b10,
    timer_phase_flag = 2'b11
  } timer_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // index 0 is channel one, index 1 channel two
  typedef struct packed {
    logic [1:0] irq_enable;
    logic [1:0] pin_level;
    logic [1:0] cap_rise;
  } ctrl_t;

endpackage : timer_oc_pkg

// >>> hw/match_channel.sv
// one 16-bit output compare channel: value bytes, inhibit, flag, level latch
// assumes: phase strobes and counter come from the parent timer
`timescale 1ns/1ps

module match_channel
  import timer_oc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // byte writes and flag-clearing reads
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  input wire logic read_status,
  input wire logic read_low,
  // timer phase strobes and counter
  input wire logic at_compare,
  input wire logic at_flag,
  input wire logic [15:0] count,
  input wire logic level_bit,
  // channel state
  output logic [15:0] value_q,
  output logic flag_q,
  output logic pin_q
);

  logic inhibit_q;
  logic hit_q;
  logic clear_armed_q;

  // ==========================================================
  // compare value: no reset, contents survive it
  always_ff @(posedge mclk) begin
    if (wr_high) begin
      value_q[15:8] <= wdata;
    end
    if (wr_low) begin
      value_q[7:0] <= wdata;
    end
  end

  // ==========================================================
  // high byte write holds off compares until the low byte lands
  always_ff @(posedge mclk) begin
    if (rst) begin
      inhibit_q <= 1'b0;
    end else if (wr_high) begin
      inhibit_q <= 1'b1;
    end else if (wr_low) begin
      inhibit_q <= 1'b0;
    end
  end

  // ==========================================================
  // match found at the compare phase, acted on at the flag phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      hit_q <= 1'b0;
    end else if (at_compare) begin
      hit_q <= !inhibit_q && (value_q == count);
    end else if (at_flag) begin
      hit_q <= 1'b0;
    end
  end

  // ==========================================================
  // flag has no reset; a new match beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (at_flag && hit_q) begin
      flag_q <= 1'b1;
    end else if (read_low && clear_armed_q) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clear_armed_q <= 1'b0;
    end else if (read_status && flag_q) begin
      clear_armed_q <= 1'b1;
    end else if (read_low) begin
      clear_armed_q <= 1'b0;
    end
  end

  // level moves to the pin latch on every match, flag set or not
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else if (at_flag && hit_q) begin
      pin_q <= level_bit;
    end
  end

endmodule : match_channel

// >>> hw/timer_output_compare_pair.sv
// output compare pair of the free-running timer, with halt and capture arming
// assumes: one bus clock mclk, synchronous inputs, a single-cycle rd/wr strobe
// How it works
// - compare value is high then low byte
// - compare once per four bus clocks
// - match sets flag, drives level to pin
// - interrupt only when enable bit set
// - high byte write inhibits until low write
// - byte write leaves other byte alone
// - level transfers even when flag already set
// - compare values and compare flags ignore reset
// - input-configured pin is undriven from the next clock on
// - counter keeps running during wait
// - halt freezes counter, resumes on wake
// - reset loads counter with fffc
// - capture edge in halt arms, flags later
// - reset out of halt drops capture
// - compare at compare phase, flag at flag phase
// - capture edge flags at next flag phase
// - flag clears by status then low read
// - counter advances every four bus clocks
`timescale 1ns/1ps
`include "timer_oc_map.svh"

module timer_output_compare_pair
  import timer_oc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // internal register bus
  input wire bus_req_t bus_req,
  output logic [7:0] bus_rdata_q,
  // low-power state
  input wire logic halt_req,
  // compare pin direction from the shared port
  input wire logic [1:0] pin_is_input,
  // capture inputs and their flag clears
  input wire logic [1:0] capture_input_pins,
  input wire logic [1:0] capture_flag_clear,
  // compare pins
  output logic match_out_pin_one,
  output logic match_out_pin_two,
  output logic match_out_oe_one,
  output logic match_out_oe_two,
  // interrupt requests
  output logic [1:0] match_irq_q,
  // capture results
  output logic [1:0] capture_flag_q,
  output logic [1:0][15:0] capture_value_q,
  // free-running counter
  output logic [15:0] timer_count_q
);

  localparam logic [7:0] HIGH_OFF [2] = '{`COMPARE_ONE_HIGH, `COMPARE_TWO_HIGH};
  localparam logic [7:0] LOW_OFF [2] = '{`COMPARE_ONE_LOW, `COMPARE_TWO_LOW};

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  timer_phase_t phase_q;
  ctrl_t ctrl_q;
  logic at_compare;
  logic at_flag;
  logic read_status;
  logic [1:0] wr_high;
  logic [1:0] wr_low;
  logic [1:0] read_low;
  logic [1:0] match_flag;
  logic [1:0] match_pin;
  logic [1:0][15:0] match_value;
  logic [1:0] match_out_oe_q;
  logic [1:0] cap_prev_q;
  logic [1:0] cap_pend_q;
  logic [1:0] cap_edge;
  logic [1:0] cap_take;

  // ==========================================================
  // timer phase sequencer
  // the whole timer runs while the processor waits; only halt stops it
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_q <= timer_phase_idle;
    end else if (!halt_req) begin
      case (phase_q)
        timer_phase_idle: begin
          phase_q <= timer_phase_compare;
        end
        timer_phase_compare: begin
          phase_q <= timer_phase_sample;
        end
        timer_phase_sample: begin
          phase_q <= timer_phase_flag;
        end
        timer_phase_flag: begin
          phase_q <= timer_phase_idle;
        end
        default: begin
          phase_q <= timer_phase_idle;
        end
      endcase
    end
  end

  // a phase frozen by halt must not fire its strobe again and again
  assign at_compare = (phase_q == timer_phase_compare) && !halt_req;
  assign at_flag = (phase_q == timer_phase_flag) && !halt_req;

  // ==========================================================
  // free-running counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_count_q <= `COUNT_RESET;
    end else if (at_flag) begin
      timer_count_q <= timer_count_q + 16'h0001;
    end
  end

  // ==========================================================
  // bus strobes
  assign read_status = bus_req.rd && hit(bus_req.addr, `TIMER_FLAG_REGISTER);

  // ==========================================================
  // control register
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= ctrl_t'(`CTRL_RESET);
    end else if (bus_req.wr && hit(bus_req.addr, `TIMER_CONTROL_REG)) begin
      ctrl_q <= ctrl_t'(bus_req.wdata[`CTRL_WIDTH-1:0]);
    end
  end

  // ==========================================================
  // compare channels
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      assign wr_high[gi] = bus_req.wr && hit(bus_req.addr, HIGH_OFF[gi]);
      assign wr_low[gi] = bus_req.wr && hit(bus_req.addr, LOW_OFF[gi]);
      assign read_low[gi] = bus_req.rd && hit(bus_req.addr, LOW_OFF[gi]);

      match_channel u_chan (
        .mclk(mclk),
        .rst(rst),
        .wr_high(wr_high[gi]),
        .wr_low(wr_low[gi]),
        .wdata(bus_req.wdata),
        .read_status(read_status),
        .read_low(read_low[gi]),
        .at_compare(at_compare),
        .at_flag(at_flag),
        .count(timer_count_q),
        .level_bit(ctrl_q.pin_level[gi]),
        .value_q(match_value[gi]),
        .flag_q(match_flag[gi]),
        .pin_q(match_pin[gi])
      );
    end
  endgenerate

  // ==========================================================
  // compare pins
  // the level latch keeps running when the pin is an input, so turning the
  // pin back to output shows the latest result rather than a stale one
  always_ff @(posedge mclk) begin
    if (rst) begin
      match_out_oe_q <= 2'b00;
    end else begin
      match_out_oe_q <= ~pin_is_input;
    end
  end

  assign match_out_pin_one = match_pin[0];
  assign match_out_pin_two = match_pin[1];
  assign match_out_oe_one = match_out_oe_q[0];
  assign match_out_oe_two = match_out_oe_q[1];

  // ==========================================================
  // interrupt requests
  always_ff @(posedge mclk) begin
    if (rst) begin
      match_irq_q <= 2'b00;
    end else begin
      match_irq_q <= match_flag & ctrl_q.irq_enable;
    end
  end

  // ==========================================================
  // capture edge detect
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      assign cap_edge[gi] = ctrl_q.cap_rise[gi] ?
        (capture_input_pins[gi] && !cap_prev_q[gi]) :
        (!capture_input_pins[gi] && cap_prev_q[gi]);
      // during halt only the first edge counts; later ones are dropped
      assign cap_take[gi] = cap_edge[gi] && !(halt_req && cap_pend_q[gi]);

      always_ff @(posedge mclk) begin
        if (rst) begin
          cap_prev_q[gi] <= 1'b0;
        end else begin
          cap_prev_q[gi] <= capture_input_pins[gi];
        end
      end

      // pending edge waits for the next flag phase; halt holds it armed
      always_ff @(posedge mclk) begin
        if (rst) begin
          cap_pend_q[gi] <= 1'b0;
        end else if (at_flag) begin
          cap_pend_q[gi] <= cap_take[gi];
        end else if (cap_take[gi]) begin
          cap_pend_q[gi] <= 1'b1;
        end
      end

      // value is one past the count seen at the edge
      always_ff @(posedge mclk) begin
        if (rst && halt_req) begin
          capture_value_q[gi] <= `CAPTURE_CLEAR;
        end else if (!rst && cap_take[gi]) begin
          capture_value_q[gi] <= timer_count_q + 16'h0001;
        end
      end

      // set wins over a clear arriving in the same cycle
      always_ff @(posedge mclk) begin
        if (rst) begin
          capture_flag_q[gi] <= 1'b0;
        end else if (at_flag && cap_pend_q[gi]) begin
          capture_flag_q[gi] <= 1'b1;
        end else if (capture_flag_clear[gi]) begin
          capture_flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // register read data, one cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_rdata_q <= `RDATA_RESET;
    end else if (bus_req.rd) begin
      if (hit(bus_req.addr, `COMPARE_ONE_HIGH)) begin
        bus_rdata_q <= match_value[0][15:8];
      end else if (hit(bus_req.addr, `COMPARE_ONE_LOW)) begin
        bus_rdata_q <= match_value[0][7:0];
      end else if (hit(bus_req.addr, `COMPARE_TWO_HIGH)) begin
        bus_rdata_q <= match_value[1][15:8];
      end else if (hit(bus_req.addr, `COMPARE_TWO_LOW)) begin
        bus_rdata_q <= match_value[1][7:0];
      end else if (hit(bus_req.addr, `TIMER_CONTROL_REG)) begin
        bus_rdata_q <= {2'b00, ctrl_q};
      end else if (hit(bus_req.addr, `TIMER_FLAG_REGISTER)) begin
        bus_rdata_q <= {4'h0, capture_flag_q, match_flag};
      end else if (hit(bus_req.addr, `COUNT_HIGH_REG)) begin
        bus_rdata_q <= timer_count_q[15:8];
      end else if (hit(bus_req.addr, `COUNT_LOW_REG)) begin
        bus_rdata_q <= timer_count_q[7:0];
      end else begin
        bus_rdata_q <= `RDATA_RESET;
      end
    end
  end

endmodule : timer_output_compare_pair

// >>> testbench/compare_pair_monitor.sv
// port assertions for the output compare pair
// assumes: bound into timer_output_compare_pair, single clock mclk
`timescale 1ns/1ps

module compare_pair_monitor
  import timer_oc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // inputs
  input wire bus_req_t bus_req,
  input wire logic halt_req,
  input wire logic [1:0] pin_is_input,
  // outputs
  input wire logic [7:0] bus_rdata_q,
  input wire logic match_out_pin_one,
  input wire logic match_out_oe_one,
  input wire logic match_out_oe_two,
  input wire logic [1:0] match_irq_q,
  input wire logic [15:0] timer_count_q
);
  // ====
  // helper: counter moved on the previous edge
  logic [15:0] prev_count_q;
  logic moved;
  always_ff @(posedge mclk) begin
    prev_count_q <= timer_count_q;
  end
  assign moved = timer_count_q != prev_count_q;

  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ====
  // counter
  count_step_a: assert property (!$past(rst) && $changed(timer_count_q)
    |-> timer_count_q == $past(timer_count_q) + 16'h1) else $error("counter skipped");
  count_hold_a: assert property (!$past(rst) && $changed(timer_count_q)
    |=> $stable(timer_count_q) [*3]) else $error("counter moved early");
  reset_load_a: assert property ($past(rst) |-> timer_count_q == 16'hfffc)
    else $error("counter not fffc");
  halt_freeze_a: assert property (!$past(rst) && $past(halt_req)
    |-> $stable(timer_count_q)) else $error("counter ran in halt");
  // ====
  // requests, pins and read data
  irq_rise_a: assert property ($rose(match_irq_q[0]) || $rose(match_irq_q[1])
    |-> $past(moved) || $past(bus_req.wr, 2)) else $error("irq rose off phase");
  irq_fall_a: assert property ($fell(match_irq_q[0]) || $fell(match_irq_q[1])
    |-> $past(bus_req.rd, 2) || $past(bus_req.wr, 2) || $past(rst))
    else $error("irq fell without access");
  pin_update_a: assert property (!$past(rst) && $changed(match_out_pin_one)
    |-> $changed(timer_count_q)) else $error("pin moved off phase");
  oe_follow_a: assert property (!$past(rst) |-> match_out_oe_one == !$past(pin_is_input[0])
    && match_out_oe_two == !$past(pin_is_input[1])) else $error("pin enable wrong");
  rdata_hold_a: assert property (!$past(rst) && !$past(bus_req.rd)
    |-> $stable(bus_rdata_q)) else $error("read data moved");
endmodule : compare_pair_monitor

bind timer_output_compare_pair compare_pair_monitor mon (.mclk(mclk), .rst(rst),
  .bus_req(bus_req), .halt_req(halt_req), .pin_is_input(pin_is_input),
  .bus_rdata_q(bus_rdata_q), .match_out_pin_one(match_out_pin_one),
  .match_out_oe_one(match_out_oe_one), .match_out_oe_two(match_out_oe_two),
  .match_irq_q(match_irq_q), .timer_count_q(timer_count_q));

// >>> testbench/cpu_bus_model.sv
// processor side of the internal register bus
// assumes: tasks called from one bench process at a time
`timescale 1ns/1ps
`include "timer_oc_map.svh"

module cpu_bus_model
  import timer_oc_pkg::*;
(
  // clock
  input wire logic mclk,
  // register bus
  output bus_req_t bus_req,
  input wire logic [7:0] bus_rdata_q
);
  initial bus_req = '0;

  // ====
  // one-cycle strobe, then an idle edge; idle address is inverted so stale values never match
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk) bus_req <= '{addr, data, 1'b1, 1'b0};
    @(posedge mclk) bus_req <= '{~addr, ~data, 1'b0, 1'b0};
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk) bus_req <= '{addr, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus_req <= '{~addr, 8'hff, 1'b0, 1'b0};
    #1 data = bus_rdata_q;
  endtask : rd

  // safe channel start: inhibit, clear the flag, then release
  task automatic load(input logic [7:0] hi, input logic [15:0] value);
    logic [7:0] junk;
    wr(hi, value[15:8]);
    rd(`TIMER_FLAG_REGISTER, junk);
    rd(hi + 8'h01, junk);
    wr(hi + 8'h01, value[7:0]);
  endtask : load
endmodule : cpu_bus_model

// >>> testbench/timer_output_compare_pair_tb_top.sv
// self-checking bench for the output compare pair
// assumes: monitor and cpu_bus_model compiled first, pkg/ on include path
`timescale 1ns/1ps
`include "timer_oc_map.svh"

module timer_output_compare_pair_tb_top
  import timer_oc_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic halt_req = 1'b0;
  logic [1:0] pin_is_input = 2'b00;
  logic [1:0] capture_input_pins = 2'b11;
  logic [1:0] capture_flag_clear = 2'b00;
  bus_req_t bus_req;
  logic [7:0] bus_rdata_q, rv;
  logic match_out_pin_one, match_out_pin_two, match_out_oe_one, match_out_oe_two;
  logic [1:0] match_irq_q, capture_flag_q;
  logic [1:0][15:0] capture_value_q;
  logic [15:0] timer_count_q, t;
  logic [7:0] keep_two_hi, keep_one_lo;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  always #10 mclk = ~mclk;

  timer_output_compare_pair dut (.mclk(mclk), .rst(rst), .bus_req(bus_req),
    .bus_rdata_q(bus_rdata_q), .halt_req(halt_req), .pin_is_input(pin_is_input),
    .capture_input_pins(capture_input_pins), .capture_flag_clear(capture_flag_clear),
    .match_out_pin_one(match_out_pin_one), .match_out_pin_two(match_out_pin_two),
    .match_out_oe_one(match_out_oe_one), .match_out_oe_two(match_out_oe_two),
    .match_irq_q(match_irq_q), .capture_flag_q(capture_flag_q),
    .capture_value_q(capture_value_q), .timer_count_q(timer_count_q));

  cpu_bus_model cpu (.mclk(mclk), .bus_req(bus_req), .bus_rdata_q(bus_rdata_q));

  // ====
  // checking and closing
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // bounded wait; the flag lands with the counter step that follows a match
  task automatic wait_count(input logic [15:0] target);
    for (int i = 0; i < 400 && timer_count_q !== target; i++) begin
      @(posedge mclk);
      #1;
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask : wait_count

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // ====
  // tests
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check_val(timer_count_q, 16'hfffc, "reset count");
    cpu.wr(`TIMER_CONTROL_REG, 8'h1c);
    t = timer_count_q + 16'h8;
    cpu.load(`COMPARE_ONE_HIGH, t);
    cpu.load(`COMPARE_TWO_HIGH, t + 16'h2);
    check_val(match_out_oe_one, 1'b1, "oe");
    wait_count(t + 16'h1);
    check_val(match_out_pin_one, 1'b1, "pin one");
    check_val(match_irq_q, 2'b01, "irq one");
    wait_count(t + 16'h3);
    check_val(match_out_pin_two, 1'b1, "pin two");
    check_val(match_irq_q, 2'b01, "irq two masked");
    cpu.rd(`TIMER_FLAG_REGISTER, rv);
    check_val(rv[1:0], 2'b11, "flags");
    cpu.rd(`COMPARE_ONE_LOW, rv);
    check_val(rv, t[7:0], "low byte");
    @(posedge mclk);
    #1;
    check_val(match_irq_q, 2'b00, "irq cleared");
    $display("test basic match done");
    // flag two still set: level still moves; channel one differs only in bit 8
    cpu.wr(`TIMER_CONTROL_REG, 8'h10);
    t = timer_count_q + 16'h6;
    keep_two_hi = t[15:8];
    cpu.wr(`COMPARE_TWO_HIGH, t[15:8]);
    cpu.wr(`COMPARE_TWO_LOW, t[7:0]);
    cpu.wr(`COMPARE_ONE_HIGH, t[15:8] ^ 8'h01);
    cpu.wr(`COMPARE_ONE_LOW, t[7:0]);
    wait_count(t + 16'h1);
    check_val(match_out_pin_two, 1'b0, "pin two relevel");
    check_val(match_out_pin_one, 1'b1, "partial match");
    $display("test relevel done");
    // high byte alone inhibits; the low write resumes, a lone low write keeps comparing
    cpu.wr(`COMPARE_ONE_HIGH, t[15:8]);
    t = timer_count_q + 16'h4;
    cpu.wr(`COMPARE_ONE_HIGH, t[15:8]);
    cpu.wr(`COMPARE_ONE_LOW, t[7:0]);
    cpu.wr(`COMPARE_ONE_HIGH, t[15:8]);
    wait_count(t + 16'h1);
    cpu.rd(`TIMER_FLAG_REGISTER, rv);
    check_val(rv[0], 1'b0, "inhibited");
    cpu.rd(`COMPARE_ONE_LOW, rv);
    check_val(rv, t[7:0], "other byte kept");
    t = timer_count_q + 16'h4;
    keep_one_lo = t[7:0];
    cpu.wr(`COMPARE_ONE_LOW, t[7:0]);
    wait_count(t + 16'h1);
    check_val(match_out_pin_one, 1'b0, "resumed");
    check_val(match_irq_q, 2'b01, "irq again");
    $display("test inhibit done");
    // pin as input, then halt with a capture edge
    @(posedge mclk) pin_is_input <= 2'b01;
    repeat (2) @(posedge mclk);
    #1;
    check_val({match_out_oe_two, match_out_oe_one}, 2'b10, "oe input");
    @(posedge mclk) halt_req <= 1'b1;
    #1 t = timer_count_q;
    @(posedge mclk) capture_input_pins <= 2'b10;
    repeat (20) @(posedge mclk);
    #1;
    check_val(timer_count_q, t, "halt freeze");
    check_val(capture_flag_q, 2'b00, "armed no flag");
    check_val(capture_value_q[0], t + 16'h1, "capture value");
    @(posedge mclk) halt_req <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    check_val(timer_count_q, t + 16'h2, "resume");
    check_val(capture_flag_q, 2'b01, "capture on wake");
    @(posedge mclk) capture_flag_clear <= 2'b01;
    @(posedge mclk) capture_flag_clear <= 2'b00;
    #1;
    check_val(capture_flag_q, 2'b00, "capture cleared");
    $display("test halt done");
    // reset keeps compare contents
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    cpu.rd(`COMPARE_TWO_HIGH, rv);
    check_val(rv, keep_two_hi, "kept high");
    cpu.rd(`COMPARE_ONE_LOW, rv);
    check_val(rv, keep_one_lo, "kept low");
    $display("test reset keep done");
    give_verdict();
  end
endmodule : timer_output_compare_pair_tb_top
